//--- logic/spbrg_pkg.sv
// Shared constants for the serial port rate generator: register indices, field positions,
// reset values, transfer lengths and the engine states.
// Assumes a plain register port with a two-bit register index and eight-bit data.
package spbrg_pkg;

   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned ADDR_W     = 2;

   localparam logic [1:0] OFF_RELOAD = 2'h0;
   localparam logic [1:0] OFF_BUFFER = 2'h1;
   localparam logic [1:0] OFF_STATUS = 2'h2;
   localparam logic [1:0] OFF_CTRL   = 2'h3;

   localparam int unsigned STAT_SMP  = 7;
   localparam int unsigned STAT_CKE  = 6;
   localparam int unsigned STAT_BUSY = 2;
   localparam int unsigned STAT_BF   = 0;

   localparam int unsigned CTRL_EN   = 0;
   localparam int unsigned CTRL_I2C  = 1;
   localparam int unsigned CTRL_CPOL = 2;
   localparam int unsigned CTRL_ACK  = 6;
   localparam int unsigned CTRL_ROOM = 7;

   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [2:0] PIN_RST    = 3'h6;

   localparam logic [4:0] SPI_LAST_HALF = 5'h0F;
   localparam logic [4:0] I2C_LAST_HALF = 5'h11;

   typedef enum logic {
      ST_IDLE,
      ST_RUN
   } spbrg_state_t;

endpackage : spbrg_pkg

//--- logic/spbrg_top.sv
// Rate generator and shift engine of a combined I2C and SPI master, with a transmit FIFO.
// Assumes one clock, an asynchronous active-low reset and a register port with one-cycle strobes.
`timescale 1ns/1ps

module spbrg_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] wr_d;
   logic [PW-1:0] rd_q;
   logic [PW-1:0] rd_d;
   logic [PW:0]   cnt_q;
   logic [PW:0]   cnt_d;
   logic          room_q;
   logic          room_d;
   logic          empty_q;
   logic          empty_d;
   logic          push;
   logic          pop;

   assign in_ready  = room_q;
   assign out_valid = ~empty_q;
   assign out_data  = mem[rd_q];

   always_comb begin
      push    = in_valid & room_q;
      pop     = out_ready & ~empty_q;
      wr_d    = push ? PW'(wr_q + 1'b1) : wr_q;
      rd_d    = pop ? PW'(rd_q + 1'b1) : rd_q;
      cnt_d   = cnt_q;
      if (push && !pop) begin
         cnt_d = (PW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = (PW+1)'(cnt_q - 1'b1);
      end
      room_d  = (cnt_d != (PW+1)'(DEPTH));
      empty_d = (cnt_d == '0);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         room_q  <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         room_q  <= room_d;
         empty_q <= empty_d;
      end
   end

   // Storage has no reset so that it maps onto plain RAM.
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
endmodule : spbrg_fifo

module spbrg_top #(
   parameter int unsigned FIFO_DEPTH = spbrg_pkg::FIFO_DEPTH
) (
   input  wire logic                         clock,
   input  wire logic                         rst_b,
   input  wire logic [spbrg_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [spbrg_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic [spbrg_pkg::DATA_W-1:0]      reg_rdata,
   output logic                              tx_room,
   output logic                              busy,
   output logic                              spi_sck,
   output logic                              spi_sdo,
   input  wire logic                         spi_sdi,
   input  wire logic                         scl_i,
   output logic                              scl_o,
   output logic                              scl_oe,
   input  wire logic                         sda_i,
   output logic                              sda_o,
   output logic                              sda_oe
);
   logic [2:0]               pin_s1_q;
   logic [2:0]               pin_s2_q;
   logic [2:0]               pin_s3_q;
   logic [2:0]               pin_f_q;
   logic [2:0]               pin_f_d;
   logic [7:0]               reload_q;
   logic [7:0]               reload_d;
   logic [7:0]               ctrl_q;
   logic [7:0]               ctrl_d;
   logic                     smp_q;
   logic                     smp_d;
   logic                     cke_q;
   logic                     cke_d;
   logic                     bf_q;
   logic                     bf_d;
   logic                     ack_q;
   logic                     ack_d;
   logic [7:0]               rxbuf_q;
   logic [7:0]               rxbuf_d;
   logic [7:0]               rdata_q;
   logic [7:0]               rdata_d;
   spbrg_pkg::spbrg_state_t  state_q;
   spbrg_pkg::spbrg_state_t  state_d;
   logic [8:0]               cnt_q;
   logic [8:0]               cnt_d;
   logic [4:0]               half_q;
   logic [4:0]               half_d;
   logic [8:0]               tx_q;
   logic [8:0]               tx_d;
   logic [8:0]               rx_q;
   logic [8:0]               rx_d;
   logic                     sck_q;
   logic                     sck_d;
   logic                     sdo_q;
   logic                     sdo_d;
   logic                     scl_oe_q;
   logic                     scl_oe_d;
   logic                     sda_oe_q;
   logic                     sda_oe_d;
   logic                     busy_q;
   logic                     pin_low_q;
   logic                     fifo_wr;
   logic                     fifo_ready;
   logic                     fifo_valid;
   logic                     fifo_pop;
   logic [7:0]               fifo_data;
   logic                     i2c;
   logic                     stall;
   logic                     last;
   logic                     mid;
   logic                     sh;
   logic                     samp;
   logic                     rd_buf;

   assign reg_rdata = rdata_q;
   assign tx_room   = fifo_ready;
   assign busy      = busy_q;
   assign spi_sck   = sck_q;
   assign spi_sdo   = sdo_q;
   assign scl_o     = pin_low_q;
   assign scl_oe    = scl_oe_q;
   assign sda_o     = pin_low_q;
   assign sda_oe    = sda_oe_q;

   assign fifo_wr  = reg_wr && (reg_addr == spbrg_pkg::OFF_BUFFER);
   assign fifo_pop = (state_q == spbrg_pkg::ST_IDLE) && ctrl_q[spbrg_pkg::CTRL_EN];

   // A full FIFO refuses the write; software watches the room flag.
   spbrg_fifo #(
      .W     (spbrg_pkg::DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst_b     (rst_b),
      .in_valid  (fifo_wr),
      .in_ready  (fifo_ready),
      .in_data   (reg_wdata),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Only agreeing second and third stages move the filtered level, so one-cycle glitches vanish.
   always_comb begin
      pin_f_d = ((pin_s2_q ~^ pin_s3_q) & pin_s2_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= spbrg_pkg::PIN_RST;
         pin_s2_q <= spbrg_pkg::PIN_RST;
         pin_s3_q <= spbrg_pkg::PIN_RST;
         pin_f_q  <= spbrg_pkg::PIN_RST;
      end else begin
         pin_s1_q <= {sda_i, scl_i, spi_sdi};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q  <= pin_f_d;
      end
   end

   always_comb begin
      i2c      = ctrl_q[spbrg_pkg::CTRL_I2C];
      last     = i2c ? (half_q == spbrg_pkg::I2C_LAST_HALF) : (half_q == spbrg_pkg::SPI_LAST_HALF);
      stall    = i2c && half_q[0] && !pin_f_q[1];
      mid      = cke_q ? ~half_q[0] : half_q[0];
      sh       = ~mid && !(!cke_q && (half_q == '0));
      samp     = smp_q ? (sh || last) : mid;
      rd_buf   = reg_rd && (reg_addr == spbrg_pkg::OFF_BUFFER);
      state_d  = state_q;
      cnt_d    = cnt_q;
      half_d   = half_q;
      tx_d     = tx_q;
      rx_d     = rx_q;
      sck_d    = sck_q;
      sdo_d    = sdo_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      rxbuf_d  = rxbuf_q;
      ack_d    = ack_q;
      bf_d     = rd_buf ? 1'b0 : bf_q;
      unique case (state_q)
         spbrg_pkg::ST_IDLE: begin
            if (!i2c) begin
               sck_d = ctrl_q[spbrg_pkg::CTRL_CPOL];
            end
            if (fifo_pop && fifo_valid) begin
               state_d = spbrg_pkg::ST_RUN;
               cnt_d   = {reload_q, 1'b1};
               half_d  = '0;
               tx_d    = {fifo_data, 1'b1};
               rx_d    = '0;
               if (i2c) begin
                  scl_oe_d = 1'b1;
                  sda_oe_d = ~fifo_data[7];
               end else begin
                  sdo_d = fifo_data[7];
               end
            end
         end
         spbrg_pkg::ST_RUN: begin
            if (stall) begin
               cnt_d = cnt_q;
            end else if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               // Loading twice the reload value plus one gives a half period of 2*(reload+1) cycles.
               cnt_d  = {reload_q, 1'b1};
               half_d = half_q + 1'b1;
               if (i2c) begin
                  if (!half_q[0]) begin
                     scl_oe_d = 1'b0;
                  end else begin
                     rx_d = {rx_q[7:0], pin_f_q[2]};
                     if (!last) begin
                        scl_oe_d = 1'b1;
                        tx_d     = {tx_q[7:0], 1'b1};
                        sda_oe_d = ~tx_q[7];
                     end else begin
                        sda_oe_d = 1'b0;
                     end
                  end
               end else begin
                  sck_d = ~sck_q;
                  if (samp) begin
                     rx_d = {rx_q[7:0], pin_f_q[0]};
                  end
                  if (sh && !last) begin
                     tx_d  = {tx_q[7:0], 1'b1};
                     sdo_d = tx_q[7];
                  end
               end
               if (last) begin
                  // The clock pin is left exactly where the final edge put it.
                  state_d = spbrg_pkg::ST_IDLE;
                  rxbuf_d = i2c ? rx_d[8:1] : rx_d[7:0];
                  ack_d   = i2c ? rx_d[0] : ack_q;
                  bf_d    = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_q   <= spbrg_pkg::ST_IDLE;
         cnt_q     <= '0;
         half_q    <= '0;
         tx_q      <= '0;
         rx_q      <= '0;
         sck_q     <= 1'b0;
         sdo_q     <= 1'b0;
         scl_oe_q  <= 1'b0;
         sda_oe_q  <= 1'b0;
         rxbuf_q   <= '0;
         ack_q     <= 1'b0;
         bf_q      <= 1'b0;
         busy_q    <= 1'b0;
         pin_low_q <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         half_q    <= half_d;
         tx_q      <= tx_d;
         rx_q      <= rx_d;
         sck_q     <= sck_d;
         sdo_q     <= sdo_d;
         scl_oe_q  <= scl_oe_d;
         sda_oe_q  <= sda_oe_d;
         rxbuf_q   <= rxbuf_d;
         ack_q     <= ack_d;
         bf_q      <= bf_d;
         busy_q    <= (state_d == spbrg_pkg::ST_RUN);
         pin_low_q <= 1'b0;
      end
   end

   // Register port; the reload value is not range-checked, so an I2C user must keep it above zero.
   always_comb begin
      reload_d = reload_q;
      ctrl_d   = ctrl_q;
      smp_d    = smp_q;
      cke_d    = cke_q;
      rdata_d  = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            spbrg_pkg::OFF_RELOAD: reload_d = reg_wdata;
            spbrg_pkg::OFF_STATUS: begin
               smp_d = reg_wdata[spbrg_pkg::STAT_SMP];
               cke_d = reg_wdata[spbrg_pkg::STAT_CKE];
            end
            spbrg_pkg::OFF_CTRL: begin
               ctrl_d = '0;
               ctrl_d[spbrg_pkg::CTRL_EN]   = reg_wdata[spbrg_pkg::CTRL_EN];
               ctrl_d[spbrg_pkg::CTRL_I2C]  = reg_wdata[spbrg_pkg::CTRL_I2C];
               ctrl_d[spbrg_pkg::CTRL_CPOL] = reg_wdata[spbrg_pkg::CTRL_CPOL];
            end
            spbrg_pkg::OFF_BUFFER: ctrl_d = ctrl_q;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            spbrg_pkg::OFF_RELOAD: rdata_d = reload_q;
            spbrg_pkg::OFF_BUFFER: rdata_d = rxbuf_q;
            spbrg_pkg::OFF_STATUS: begin
               rdata_d[spbrg_pkg::STAT_SMP]  = smp_q;
               rdata_d[spbrg_pkg::STAT_CKE]  = cke_q;
               rdata_d[spbrg_pkg::STAT_BUSY] = busy_q;
               rdata_d[spbrg_pkg::STAT_BF]   = bf_q;
            end
            spbrg_pkg::OFF_CTRL: begin
               rdata_d = ctrl_q;
               rdata_d[spbrg_pkg::CTRL_ACK]  = ack_q;
               rdata_d[spbrg_pkg::CTRL_ROOM] = fifo_ready;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         reload_q <= spbrg_pkg::RELOAD_RST;
         ctrl_q   <= spbrg_pkg::CTRL_RST;
         smp_q    <= spbrg_pkg::STATUS_RST[spbrg_pkg::STAT_SMP];
         cke_q    <= spbrg_pkg::STATUS_RST[spbrg_pkg::STAT_CKE];
         rdata_q  <= '0;
      end else begin
         reload_q <= reload_d;
         ctrl_q   <= ctrl_d;
         smp_q    <= smp_d;
         cke_q    <= cke_d;
         rdata_q  <= rdata_d;
      end
   end
endmodule : spbrg_top

//--- sim/spbrg_properties.sv
// Concurrent checks on the top ports of the rate generator.
// Assumes it is bound onto spbrg_top and shadows the register writes itself.
`timescale 1ns/1ps
module spbrg_properties (
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       tx_room,
   input wire logic       busy,
   input wire logic       spi_sck,
   input wire logic       spi_sdo,
   input wire logic       spi_sdi,
   input wire logic       scl_i,
   input wire logic       scl_o,
   input wire logic       scl_oe,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe
);
   logic [7:0] rel_q;
   logic       en_q, i2c_q, cpol_q, smp_q, cke_q;
   logic       sck_q, oe_q, busy_q, seen_q;
   logic [9:0] hcnt_q, ocnt_q, half;
   logic [4:0] tcnt_q;
   logic       sck_chg;
   assign half    = {1'h0, rel_q, 1'h0} + 10'h002;
   assign sck_chg = spi_sck != sck_q;
   // The settings are copied from the bus, since the checker cannot see inside.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rel_q  <= 8'h00;
         {smp_q, cke_q, cpol_q, i2c_q, en_q} <= 5'h00;
         {sck_q, oe_q, busy_q, seen_q} <= 4'h0;
         hcnt_q <= 10'h000;
         ocnt_q <= 10'h000;
         tcnt_q <= 5'h00;
      end else begin
         if (reg_wr && reg_addr == spbrg_pkg::OFF_RELOAD) rel_q <= reg_wdata;
         if (reg_wr && reg_addr == spbrg_pkg::OFF_STATUS) {smp_q, cke_q} <= reg_wdata[7:6];
         if (reg_wr && reg_addr == spbrg_pkg::OFF_CTRL) {cpol_q, i2c_q, en_q} <= reg_wdata[2:0];
         sck_q  <= spi_sck;
         oe_q   <= scl_oe;
         busy_q <= busy;
         seen_q <= busy && (seen_q || sck_chg);
         hcnt_q <= sck_chg ? 10'h001 : hcnt_q + 10'h001;
         ocnt_q <= (scl_oe != oe_q) ? 10'h001 : ocnt_q + 10'h001;
         tcnt_q <= (busy && !busy_q) ? 5'h00 : tcnt_q + {4'h0, sck_chg};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   start_on_write_a:
      assert property (reg_wr && reg_addr == spbrg_pkg::OFF_BUFFER && tx_room && en_q && !busy |-> ##[1:4] busy)
         else $error("no transfer after a buffer write");
   sck_half_a:
      assert property (busy && seen_q && !i2c_q && sck_chg |-> hcnt_q == half)
         else $error("serial clock half period wrong");
   i2c_low_a:
      assert property (busy && i2c_q && !scl_oe && oe_q |-> ocnt_q == half)
         else $error("clock low phase wrong in two-wire mode");
   sck_hold_a:
      assert property ($fell(busy) && !i2c_q |=> $stable(spi_sck)[*2])
         else $error("serial clock moved after the transfer");
   toggle_count_a:
      assert property ($fell(busy) && !i2c_q |=> tcnt_q == 5'h10)
         else $error("wrong number of clock reloads");
   status_read_a:
      assert property (reg_rd && reg_addr == spbrg_pkg::OFF_STATUS |=> reg_rdata[7:6] == {smp_q, cke_q})
         else $error("sample phase or edge bit wrong");
   late_shift_a:
      assert property (busy && busy_q && !i2c_q && cke_q && $changed(spi_sdo) |-> sck_chg && spi_sck == cpol_q)
         else $error("data changed off the idle-going edge");
   early_shift_a:
      assert property (busy && busy_q && !i2c_q && !cke_q && $changed(spi_sdo) |-> sck_chg && spi_sck != cpol_q)
         else $error("data changed off the active-going edge");
endmodule : spbrg_properties

//--- sim/spbrg_slave_model.sv
// Far-side slave: an SPI slave that returns a reply byte, and a two-wire slave that acknowledges.
// Assumes it is paced by the system clock and treated as selected while the master is busy.
`timescale 1ns/1ps
module spbrg_slave_model (
   input  wire logic       clock,
   input  wire logic       busy,
   input  wire logic       spi_sck,
   input  wire logic       spi_sdo,
   output logic            spi_sdi,
   input  wire logic       cpol,
   input  wire logic       cke,
   input  wire logic [7:0] reply,
   output logic [7:0]      got,
   output logic [7:0]      cnt,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       nack,
   output logic            sda_pull,
   output logic [7:0]      igot
);
   logic       sel_q, sck_q, scl_q, act;
   logic [7:0] tx, rx;
   logic [3:0] n, k;
   assign spi_sdi = busy ? tx[7] : ~tx[7];
   assign act     = (spi_sck != cpol) == cke;
   initial begin
      {cnt, got, igot, rx, tx, n, k} = '0;
      {sel_q, sck_q, sda_pull} = '0;
      scl_q = 1'h1;
   end
   // Selection is held one cycle past busy so a last edge that lands with busy falling is kept.
   // Busy drops for one cycle only between queued bytes, so every low cycle rearms the slave.
   // With the edge bit clear the first bit is out before the first edge, so that edge shifts nothing.
   always @(posedge clock) begin
      sel_q <= busy;
      sck_q <= spi_sck;
      scl_q <= scl;
      if (spi_sck != sck_q && act && (busy || sel_q)) begin
         rx <= {rx[6:0], spi_sdo};
         if (busy) n <= n + 4'h1;
         if (n == 4'h7) got <= {rx[6:0], spi_sdo};
         if (n == 4'h7) cnt <= cnt + 8'h01;
      end else if (busy && spi_sck != sck_q && (cke || n != 4'h0)) tx <= {tx[6:0], ~tx[7]};
      if (busy && scl && !scl_q && k < 4'h8) igot <= {igot[6:0], sda};
      if (busy && scl && !scl_q) k <= k + 4'h1;
      if (busy && !scl && scl_q && k == 4'h8) sda_pull <= !nack;
      if (busy && !scl && scl_q && k == 4'h9) sda_pull <= 1'h0;
      if (!busy) begin
         n        <= 4'h0;
         k        <= 4'h0;
         tx       <= reply;
         sda_pull <= 1'h0;
      end
   end
endmodule : spbrg_slave_model

//--- sim/spbrg_top_test.sv
// Bench for the rate generator: registers, four SPI clock modes, buffer fill and two-wire bytes.
// Assumes the slave model on the far side and pull-ups on both two-wire lines.
`timescale 1ns/1ps
module spbrg_top_test;
   logic       clock, rst_b, reg_wr, reg_rd, busy, tx_room, spi_sck, spi_sdo, spi_sdi;
   logic       scl_o, scl_oe, sda_o, sda_oe, sda_pull, scl_w, sda_w, cpol, cke, nack;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, reply, got, cnt, igot, base;
   int         bad_count, checked, i;
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || sda_pull);
   spbrg_top dut (
      .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_room(tx_room), .busy(busy), .spi_sck(spi_sck),
      .spi_sdo(spi_sdo), .spi_sdi(spi_sdi), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
   spbrg_slave_model peer (
      .clock(clock), .busy(busy), .spi_sck(spi_sck), .spi_sdo(spi_sdo), .spi_sdi(spi_sdi),
      .cpol(cpol), .cke(cke), .reply(reply), .got(got), .cnt(cnt), .scl(scl_w), .sda(sda_w),
      .nack(nack), .sda_pull(sda_pull), .igot(igot));
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'h0;
      @(negedge clock);
      chk(what, reg_rdata, exp);
   endtask : rd
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   // Queued bytes go out with one idle cycle between them, so a long quiet run means drained.
   task automatic idle_wait;
      int q;
      int m;
      q = 0;
      for (m = 0; q < 12; m++) begin
         @(posedge clock);
         q = (busy === 1'h0) ? q + 1 : 0;
         if (m > 20000) bad_count++;
         if (m > 20000) report_and_stop;
      end
   endtask : idle_wait
   initial begin
      {rst_b, reg_wr, reg_rd, cpol, cke, nack} = '0;
      {reg_addr, reg_wdata, reply, bad_count, checked} = '0;
      repeat (12) @(posedge clock);
      rst_b <= 1'h1;
      rd(spbrg_pkg::OFF_STATUS, 8'h00, "status reset");
      rd(spbrg_pkg::OFF_RELOAD, 8'h00, "reload reset");
      rd(spbrg_pkg::OFF_CTRL, 8'h80, "control reset");
      wr(spbrg_pkg::OFF_STATUS, 8'hFF);
      rd(spbrg_pkg::OFF_STATUS, 8'hC0, "status bits");
      wr(spbrg_pkg::OFF_RELOAD, 8'h03);
      rd(spbrg_pkg::OFF_RELOAD, 8'h03, "reload");
      for (i = 0; i < 4; i++) begin
         cke   <= i[0];
         cpol  <= i[1];
         reply <= 8'hC3 ^ i[7:0];
         base = cnt;
         wr(spbrg_pkg::OFF_STATUS, {i[1], i[0], 6'h00});
         wr(spbrg_pkg::OFF_CTRL, {5'h00, i[1], 2'h1});
         wr(spbrg_pkg::OFF_BUFFER, 8'hA5);
         wr(spbrg_pkg::OFF_BUFFER, 8'h3C ^ i[7:0]);
         idle_wait;
         chk("spi count", cnt - base, 8'h02);
         chk("spi sent", got, 8'h3C ^ i[7:0]);
         chk("sck idle", {7'h00, spi_sck}, {7'h00, i[1]});
         rd(spbrg_pkg::OFF_STATUS, {i[1], i[0], 6'h01}, "full flag");
         rd(spbrg_pkg::OFF_BUFFER, 8'hC3 ^ i[7:0], "spi received");
         rd(spbrg_pkg::OFF_STATUS, {i[1], i[0], 6'h00}, "flag cleared");
      end
      wr(spbrg_pkg::OFF_CTRL, 8'h00);
      cpol <= 1'h0;
      base = cnt;
      for (i = 0; i < 33; i++) wr(spbrg_pkg::OFF_BUFFER, i[7:0]);
      chk("room", {7'h00, tx_room}, 8'h00);
      rd(spbrg_pkg::OFF_CTRL, 8'h00, "room bit");
      wr(spbrg_pkg::OFF_CTRL, 8'h01);
      idle_wait;
      chk("drained", cnt - base, 8'h20);
      chk("last byte", got, 8'h1F);
      chk("room back", {7'h00, tx_room}, 8'h01);
      for (i = 0; i < 2; i++) begin
         nack <= i[0];
         wr(spbrg_pkg::OFF_CTRL, 8'h03);
         wr(spbrg_pkg::OFF_BUFFER, 8'h96 ^ i[7:0]);
         idle_wait;
         chk("i2c byte", igot, 8'h96 ^ i[7:0]);
         chk("lines released", {6'h00, scl_oe, sda_oe}, 8'h00);
         chk("line levels", {6'h00, scl_o, sda_o}, 8'h00);
         rd(spbrg_pkg::OFF_CTRL, {1'h1, i[0], 6'h03}, "ack bit");
      end
      report_and_stop;
   end
endmodule : spbrg_top_test
bind spbrg_top spbrg_properties chk_i (
   .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_room(tx_room), .busy(busy), .spi_sck(spi_sck),
   .spi_sdo(spi_sdo), .spi_sdi(spi_sdi), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
